// ===== rtl/edq_pkg.sv
// Purpose: Shared constants for the edge delay qualifier
// Assumes: 40 MHz bus clock, one aligned word per register
// Notes: Master period is a count of bus clock cycles held in a register
`default_nettype none
package edq_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	// Least master period in ns and its cycle count, rounded up
	localparam int unsigned MASTER_MIN_NS = 1000;
	localparam int unsigned MASTER_MIN_CYC =
		(MASTER_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned START_PERIODS = 500;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CODE = 8'h0c;
	// Control fields
	localparam int unsigned CTRL_BOTH = 0;
	localparam int unsigned CTRL_CUR_OK = 1;
	localparam int unsigned CTRL_START = 2;
	localparam logic [3:0] CODE_RST = 4'h0;
	localparam logic [2:0] CTRL_RST = 3'b010;
	localparam logic [23:0] PERIOD_RST = 24'h00_0028;
	localparam int unsigned PERIOD_W = 24;
	localparam int unsigned CNT_W = 22;
	localparam int unsigned POL_BIT = 3;
	typedef enum logic [1:0] {EDQ_START, EDQ_IDLE, EDQ_TIMING}
		edq_state_type;
endpackage : edq_pkg
`default_nettype wire

// ===== rtl/edq_ratio.sv
// Purpose: Map the setting code to a divider ratio exponent
// Assumes: Code is a 4-bit value
// Notes: Ratio is two to the returned exponent
`default_nettype none
module edq_ratio (
	// Setting
	input wire logic [3:0] code,
	// Ratio
	output logic [4:0] ratio_log2
);
	import edq_pkg::*;
	logic [2:0] idx;
	always_comb begin
		// Upper codes mirror the lower ones
		idx = code[POL_BIT] ? ~code[2:0] : code[2:0];
		// Ratios 1, 8, 64 ... 2097152
		ratio_log2 = 5'(3 * idx);
	end
endmodule : edq_ratio
`default_nettype wire

// ===== rtl/edq_master.sv
// Purpose: Master oscillator tick generator
// Assumes: Period is a count of bus clocks, floored at the minimum
// Notes: Runs only while enabled and current is adequate
`default_nettype none
module edq_master (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic run,
	input wire logic [23:0] period,
	// Tick
	output logic tick
);
	import edq_pkg::*;
	logic [23:0] cnt_q;
	logic [23:0] per;
	always_comb begin
		per = (period < 24'(MASTER_MIN_CYC)) ? 24'(MASTER_MIN_CYC) : period;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 24'h00_0000;
		end else if (!run) begin
			cnt_q <= 24'h00_0000;
		end else if (cnt_q >= per - 24'h00_0001) begin
			cnt_q <= 24'h00_0000;
		end else begin
			cnt_q <= cnt_q + 24'h00_0001;
		end
	end
	// One period floor gives at least one microsecond per tick
	assign tick = run && (cnt_q >= per - 24'h00_0001);
endmodule : edq_master
`default_nettype wire

// ===== rtl/edq_top.sv
// Purpose: Edge delay qualifier with AHB-Lite register access
// Assumes: Input is synchronous to hclk
// Notes: Delay is ratio times master period
`default_nettype none
// What this block does
// - A 4-bit setting code sets both divider ratio and polarity.
// - Top bit of setting code is the polarity select bit.
// - Single-edge: polarity 0 delays rising, 1 delays falling edges.
// - Both-edge: delay both edges, polarity 1 inverts output.
// - Eight ratios: 1, 8, 64, 512, 4096, 32768, 262144, 2097152.
// - Codes 0-7 ascending ratios; codes 8-15 same ratios reversed.
// - Delay equals selected ratio times master period.
// - Delayed edge starts master oscillator; output changes after duration.
// - Low programming current holds pending transition until current returns.
// - Master oscillator period is never below one microsecond.
// - Delays span one microsecond up to about 879,609 seconds (24-bit period).
// - Delayed transitions that do not persist never reach the output.
// - Single-edge: early return abandons timing; next edge restarts it.
// - Single-edge: the non-delayed transition passes at once.
// - Both-edge: short level restarts timing on next transition.
// - During start-up output is low and input ignored.
module edq_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Signal path
	input wire logic sig_in,
	output logic sig_out
);
	import edq_pkg::*;
	////////////////////////////////////////////////////////////////////////
	logic [3:0] divide_code_q;
	logic [2:0] ctrl_q;
	logic [23:0] master_period_q;
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;
	edq_state_type state_q;
	logic out_q;
	logic level_q;
	logic [CNT_W-1:0] cnt_q;
	logic [9:0] start_q;
	logic polarity_select_bit;
	logic both_mode;
	logic cur_ok;
	logic [4:0] ratio_log2;
	logic [CNT_W-1:0] last_cnt;
	logic tick;
	logic run;
	logic target;
	logic delayed_edge;
	logic take;
	logic start_done;
	logic edge_seen;
	logic pulse_short;
	logic delay_done;
	assign polarity_select_bit = divide_code_q[POL_BIT];
	assign both_mode = ctrl_q[CTRL_BOTH];
	assign cur_ok = ctrl_q[CTRL_CUR_OK];
	////////////////////////////////////////////////////////////////////////
	// Bus slave
	assign take = hsel && hready && htrans[1];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= take && hwrite;
			addr_q <= haddr;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			divide_code_q <= CODE_RST;
			ctrl_q <= CTRL_RST;
			master_period_q <= PERIOD_RST;
		end else if (wr_pend_q) begin
			unique case (addr_q)
				// Code steers both ratio and polarity
				OFS_CODE: divide_code_q <= hwdata[3:0];
				OFS_CTRL: ctrl_q <= hwdata[2:0];
				OFS_PERIOD: master_period_q <= hwdata[PERIOD_W-1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			unique case (haddr)
				OFS_CODE: rdata_q <= {28'h000_0000, divide_code_q};
				OFS_CTRL: rdata_q <= {29'h0000_0000, ctrl_q};
				OFS_PERIOD: rdata_q <= {8'h00, master_period_q};
				OFS_STATUS: rdata_q <= {28'h000_0000,
					state_q == EDQ_START, state_q == EDQ_TIMING,
					level_q, out_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Ratio and master oscillator
	edq_ratio u_ratio (
		.code(divide_code_q),
		.ratio_log2(ratio_log2)
	);
	// Terminal count is ratio minus one master periods
	assign last_cnt = CNT_W'((23'h00_0001 << ratio_log2) - 23'h00_0001);
	// Oscillator runs while timing or starting, stalled by low current
	assign run = (state_q != EDQ_IDLE) && cur_ok;
	edq_master u_master (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(run),
		.period(master_period_q),
		.tick(tick)
	);
	////////////////////////////////////////////////////////////////////////
	// Delay state machine
	// Output level that the input asks for
	assign target = both_mode ? (sig_in ^ polarity_select_bit) : sig_in;
	// Single-edge: only the selected edge is timed
	assign delayed_edge = both_mode ? 1'b1 :
		(target ^ polarity_select_bit);
	// Qualifying events for the state machine
	assign start_done = (state_q == EDQ_START) && !ctrl_q[CTRL_START] &&
		tick && (start_q == 10'(START_PERIODS - 1));
	assign edge_seen = (state_q == EDQ_IDLE) && (target != out_q);
	// Input went back before the delay ran out
	assign pulse_short = (state_q == EDQ_TIMING) && (target == out_q);
	assign delay_done = (state_q == EDQ_TIMING) && !pulse_short && tick &&
		(cnt_q == last_cnt);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level_q <= 1'h0;
		end else begin
			level_q <= sig_in;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= EDQ_START;
		end else begin
			unique case (state_q)
				EDQ_START: begin
					if (start_done) begin
						state_q <= EDQ_IDLE;
					end
				end
				EDQ_IDLE: begin
					if (edge_seen && delayed_edge) begin
						state_q <= EDQ_TIMING;
					end
				end
				EDQ_TIMING: begin
					// Pulse too short: drop it, rearm on next edge
					if (pulse_short || delay_done) begin
						state_q <= EDQ_IDLE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_q <= 1'h0;
		end else begin
			unique case (state_q)
				EDQ_START: begin
					// Output low, input ignored until start-up ends
					out_q <= start_done ? target : 1'h0;
				end
				EDQ_IDLE: begin
					if (edge_seen && !delayed_edge) begin
						out_q <= target;
					end
				end
				EDQ_TIMING: begin
					if (delay_done) begin
						out_q <= target;
					end
				end
			endcase
		end
	end
	// Master periods counted since the timed edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
		end else if (state_q != EDQ_TIMING) begin
			cnt_q <= '0;
		end else if (tick && !pulse_short && !delay_done) begin
			cnt_q <= cnt_q + 1'h1;
		end
	end
	// Start-up length in master periods; hold bit restarts it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= 10'h000;
		end else if (state_q == EDQ_START) begin
			if (ctrl_q[CTRL_START]) begin
				start_q <= 10'h000;
			end else if (tick && !start_done) begin
				start_q <= start_q + 10'h001;
			end
		end
	end
	assign sig_out = out_q;
endmodule : edq_top
`default_nettype wire

// ===== test/edq_top_assertions.sv
// Purpose: Port assertions for edq_top
// Assumes: Master period at its floor of 40 cycles
// Notes: Bound to every edq_top
`default_nettype none
module edq_top_chk
import edq_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Signal path
	input wire logic sig_in,
	input wire logic sig_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic rd;
	logic [15:0] up_q;
	logic [5:0] st_q;
	assign rd = hsel && hreadyout && htrans[1] && !hwrite;
	// Cycles since reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) up_q <= '0;
		else if (up_q != '1) up_q <= up_q + 1'h1;
	end
	// Cycles the input has held its level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) st_q <= '0;
		else if ($changed(sig_in)) st_q <= '0;
		else if (st_q != '1) st_q <= st_q + 1'h1;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_always: assert property (hreadyout)
		else $error("wait state seen");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_start_low: assert property ($rose(hresetn) |-> !sig_out)
		else $error("output high at release");
	a_start_hold: assert property
		(up_q < START_PERIODS * MASTER_MIN_CYC |-> !sig_out)
		else $error("output high in start-up");
	a_edge_qual: assert property ($changed(sig_out) |->
		st_q < 3 || st_q >= MASTER_MIN_CYC - 1)
		else $error("output moved on a short input level");
	a_read_hold: assert property (!$past(rd) |-> $stable(hrdata))
		else $error("read data moved");
	a_unmapped_zero: assert property
		(rd && haddr[7:2] > 6'h3 |=> hrdata == '0)
		else $error("unmapped read not zero");
	a_code_width: assert property
		(rd && haddr == OFS_CODE |=> hrdata[31:4] == '0)
		else $error("code wider than four bits");
	c_rise: cover property ($rose(sig_out));
	c_fall: cover property ($fell(sig_out));
	c_unmapped: cover property (rd && haddr[7:2] > 6'h3);
endmodule : edq_top_chk
bind edq_top edq_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.sig_in(sig_in), .sig_out(sig_out));
`default_nettype wire

// ===== test/edq_switch.sv
// Purpose: Bouncing switch driving the logic input
// Assumes: Calls start just after a rising edge
// Notes: Each bounce lasts four cycles
`default_nettype none
module edq_switch (
	// Clock
	input wire logic hclk,
	// Contact
	output logic sig
);
	timeunit 1ns;
	timeprecision 100ps;
	initial sig = 1'h0;
	task automatic press(input logic lvl, input int n);
		for (int i = 0; i < n; i++) begin
			sig <= ~sig;
			repeat (4) @(posedge hclk);
		end
		sig <= lvl;
		@(posedge hclk);
	endtask : press
endmodule : edq_switch
`default_nettype wire

// ===== test/edge_delay_qualifier_test.sv
// Purpose: Self-checking bench for edq_top
// Assumes: Master period left at 40 cycles
// Notes: Ratio codes kept short to bound the run
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %0t mismatch", $time); end end
module edge_delay_qualifier_test
import edq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic sig_in, sig_out;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, v;
	logic [3:0] c;
	int mismatches, num_checks, cyc, d;
	logic [3:0] codes [6] = '{4'hf, 4'he, 4'h0, 4'h1, 4'h2, 4'hd};
	assign hready = hreadyout;
	edq_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .sig_in(sig_in),
		.sig_out(sig_out));
	edq_switch u_src (.hclk(hclk), .sig(sig_in));
	initial begin
		hclk = 1'h0;
		forever #12.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 80000) begin
			$display("[FAIL] %0t timeout", $time);
			mismatches++;
			results();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'h1; haddr <= a; htrans <= 2'h2; hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'h0; htrans <= 2'h0; hwdata <= wd;
		do @(posedge hclk); while (!hreadyout);
		v = hrdata;
	endtask : bus
	// Drive a level, check output before and after the delay
	task automatic step(input logic l, input int n, input int w,
		input logic b, input logic a);
		u_src.press(l, n);
		repeat (w) @(posedge hclk);
		@(negedge hclk);
		if (w > 0) `CHK(sig_out, b)
		repeat (8) @(posedge hclk);
		@(negedge hclk);
		`CHK(sig_out, a)
		@(posedge hclk);
	endtask : step
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		bus(0, OFS_CTRL, 0);
		`CHK(v[2:0], CTRL_RST)
		bus(0, OFS_PERIOD, 0);
		`CHK(v[23:0], PERIOD_RST)
		bus(1, 8'h10, 32'hffff_ffff);
		bus(0, 8'h10, 0);
		`CHK(v, 32'h0000_0000)
		bus(1, OFS_CODE, 32'h0000_001f);
		bus(0, OFS_CODE, 0);
		`CHK(v, 32'h0000_000f)
		bus(0, OFS_STATUS, 0);
		`CHK(v[3:0], 4'h8)
		// Hold start-up a while; its count restarts on release
		bus(1, OFS_CTRL, 32'h0000_0006);
		repeat (200) @(posedge hclk);
		bus(1, OFS_CTRL, 32'h0000_0002);
		$display("registers done");
		step(1, 0, 19860, 0, 0);
		step(1, 0, 200, 1, 1);
		foreach (codes[i]) begin
			c = codes[i];
			d = 40 << (3 * (c[3] ? 15 - c : c));
			bus(1, OFS_CODE, {28'h0, c});
			step(c[3], 0, 0, 0, c[3]);
			step(!c[3], 5, d - 5, c[3], !c[3]);
			step(c[3], 0, 0, 0, c[3]);
			step(!c[3], 0, d / 2, c[3], c[3]);
			step(c[3], 0, d, c[3], c[3]);
		end
		$display("single-edge done");
		bus(1, OFS_CODE, 0);
		step(0, 0, 0, 0, 0);
		bus(1, OFS_CTRL, 0);
		step(1, 0, 100, 0, 0);
		bus(0, OFS_STATUS, 0);
		`CHK(v[3:0], 4'h6)
		bus(1, OFS_CTRL, 32'h0000_0002);
		step(1, 0, 50, 1, 1);
		bus(1, OFS_CTRL, 32'h0000_0003);
		step(0, 0, 35, 1, 0);
		step(1, 0, 16, 0, 0);
		step(0, 0, 35, 0, 0);
		step(1, 0, 35, 0, 1);
		bus(1, OFS_CODE, 32'h0000_000f);
		step(0, 0, 45, 1, 1);
		step(1, 0, 35, 1, 0);
		bus(1, OFS_PERIOD, 32'h0000_0001);
		bus(0, OFS_PERIOD, 0);
		`CHK(v[23:0], 24'h00_0001)
		step(0, 0, 35, 0, 1);
		$display("both-edge done");
		results();
	end
endmodule : edge_delay_qualifier_test
`default_nettype wire
